// ### hw/ucb_decision.v
// Current unbalance decision logic with settings registers and events.
// Assumes magnitudes, blocking input and register port on the same clock.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ucb_defs.vh"

// Behaviour
// (R1) Combine flags, enable, start-only, blocking; default off
// (R2) Difference percentage of maximum above setting
// (R3) Start only when maximum above 0.1 rated
// (R4) Start only when maximum below 1.5 rated
// (R5) Start-only mode suppresses trip; default false
// (R6) Start percentage 10 to 90, default 50
// (R7) Delay 100 to 60000 ms, default 1000
// (R8) Delay timed from fault condition appearance
// (R9) Blocking input holds start and trip inactive
// (R10) General start while conditions met, enabled, unblocked
// (R11) General trip after condition persists set delay
// (R12) On/off events for start and trip changes
// (R13) Difference flag releases below 0.95 of setting
// (R14) Condition loss clears timer and trip
module ucb_decision #(
    parameter MAG_W = 16,
    parameter [MAG_W-1:0] RATED_MAG = 16'h1000,
    parameter TICK_CYCLES = `UCB_TICK_CYCLES
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // Phase magnitudes and blocking
    input wire [MAG_W-1:0] mag_l1_i,
    input wire [MAG_W-1:0] mag_l2_i,
    input wire [MAG_W-1:0] mag_l3_i,
    input wire unbalance_block_input_i,
    // Register port
    input wire [3:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    // Protection outputs
    output reg unbalance_general_start_o,
    output reg unbalance_general_trip_o,
    // Events
    output reg start_event_o,
    output reg start_event_value_o,
    output reg trip_event_o,
    output reg trip_event_value_o,
    // Interrupt
    output reg irq_o
);

    localparam PRE_W = 32;
    localparam [PRE_W-1:0] TICK_LAST = TICK_CYCLES - 1;

    // ==========================================================
    // Declarations
    reg enable_ff;
    reg start_only_ff;
    reg [6:0] pct_ff;
    reg [15:0] delay_ff;
    reg [3:0] int_stat_ff;
    reg [3:0] int_mask_ff;
    reg [PRE_W-1:0] pre_ff;
    reg [15:0] ms_ff;
    reg nxt_enable;
    reg nxt_start_only;
    reg [6:0] nxt_pct;
    reg [15:0] nxt_delay;
    reg [3:0] nxt_int_stat;
    reg [3:0] nxt_int_mask;
    reg [15:0] nxt_rdata;
    reg [PRE_W-1:0] nxt_pre;
    reg [15:0] nxt_ms;
    reg nxt_start;
    reg nxt_trip;
    reg [3:0] events;
    wire diff_flag;
    wire max_current_sufficient_flag;
    wire max_current_below_fault_flag;
    wire fault_cond;
    wire wr_ctrl;
    wire wr_pct;
    wire wr_delay;
    wire wr_mask;
    wire rd_int;

    // ==========================================================
    // Magnitude evaluation
    ucb_evaluate #(
        .MAG_W(MAG_W),
        .RATED_MAG(RATED_MAG)
    ) u_evaluate (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .mag_l1_i(mag_l1_i),
        .mag_l2_i(mag_l2_i),
        .mag_l3_i(mag_l3_i),
        .pct_i(pct_ff),
        .diff_flag_o(diff_flag),
        .max_current_sufficient_flag_o(max_current_sufficient_flag),
        .max_current_below_fault_flag_o(max_current_below_fault_flag)
    );

    // ==========================================================
    // Write decode and interrupt status read decode
    assign wr_ctrl = reg_wr_i && (reg_addr_i == `UCB_ADDR_CTRL);
    assign wr_pct = reg_wr_i && (reg_addr_i == `UCB_ADDR_PCT);
    assign wr_delay = reg_wr_i && (reg_addr_i == `UCB_ADDR_DELAY);
    assign wr_mask = reg_wr_i && (reg_addr_i == `UCB_ADDR_INT_MASK);
    assign rd_int = reg_rd_i && (reg_addr_i == `UCB_ADDR_INT_STAT);

    // ==========================================================
    // Settings
    always @* begin
        nxt_enable = enable_ff;
        nxt_start_only = start_only_ff;
        nxt_pct = pct_ff;
        nxt_delay = delay_ff;
        nxt_int_mask = int_mask_ff;
        if (wr_ctrl) begin
            nxt_enable = reg_wdata_i[`UCB_CTRL_ENABLE];
            nxt_start_only = reg_wdata_i[`UCB_CTRL_START_ONLY];
        end
        if (wr_pct) begin
            // Clamp to the allowed percentage range
            if (reg_wdata_i < {9'h000, `UCB_PCT_MIN}) begin
                nxt_pct = `UCB_PCT_MIN; // [R6]
            end else if (reg_wdata_i > {9'h000, `UCB_PCT_MAX}) begin
                nxt_pct = `UCB_PCT_MAX; // [R6]
            end else begin
                nxt_pct = reg_wdata_i[6:0]; // [R6]
            end
        end
        if (wr_delay) begin
            // Clamp to the allowed delay range
            if (reg_wdata_i < `UCB_DELAY_MIN) begin
                nxt_delay = `UCB_DELAY_MIN; // [R7]
            end else if (reg_wdata_i > `UCB_DELAY_MAX) begin
                nxt_delay = `UCB_DELAY_MAX; // [R7]
            end else begin
                nxt_delay = reg_wdata_i; // [R7]
            end
        end
        if (wr_mask) begin
            nxt_int_mask = reg_wdata_i[3:0];
        end
    end

    // ==========================================================
    // Start condition
    assign fault_cond = diff_flag // [R2]
        && max_current_sufficient_flag // [R3]
        && max_current_below_fault_flag // [R4]
        && enable_ff // [R1]
        && !unbalance_block_input_i; // [R9]

    // ==========================================================
    // Delay timer
    always @* begin
        nxt_pre = pre_ff;
        nxt_ms = ms_ff;
        nxt_start = fault_cond; // [R10]
        nxt_trip = 1'b0;
        if (!fault_cond) begin
            // Loss of condition restarts timing from zero
            nxt_pre = {PRE_W{1'b0}}; // [R14]
            nxt_ms = 16'h0000; // [R14]
        end else begin
            // Timing runs from the condition itself
            if (pre_ff == TICK_LAST) begin
                nxt_pre = {PRE_W{1'b0}}; // [R8]
                if (ms_ff != 16'hFFFF) begin
                    nxt_ms = ms_ff + 16'h0001; // [R8]
                end
            end else begin
                nxt_pre = pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
            end
            if ((nxt_ms >= delay_ff) && !start_only_ff) begin
                nxt_trip = 1'b1; // [R11] [R5]
            end
        end
    end

    // ==========================================================
    // Events and interrupt status
    always @* begin
        events = 4'h0;
        events[`UCB_INT_START_ON] = nxt_start && !unbalance_general_start_o; // [R12]
        events[`UCB_INT_START_OFF] = !nxt_start && unbalance_general_start_o; // [R12]
        events[`UCB_INT_TRIP_ON] = nxt_trip && !unbalance_general_trip_o; // [R12]
        events[`UCB_INT_TRIP_OFF] = !nxt_trip && unbalance_general_trip_o; // [R12]
        nxt_int_stat = int_stat_ff;
        if (rd_int) begin
            nxt_int_stat = 4'h0;
        end
        // A new event wins over the clearing read
        nxt_int_stat = nxt_int_stat | events;
    end

    // ==========================================================
    // Read data
    always @* begin
        nxt_rdata = 16'h0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `UCB_ADDR_CTRL: begin
                    nxt_rdata[`UCB_CTRL_ENABLE] = enable_ff;
                    nxt_rdata[`UCB_CTRL_START_ONLY] = start_only_ff;
                end
                `UCB_ADDR_PCT: begin
                    nxt_rdata = {9'h000, pct_ff};
                end
                `UCB_ADDR_DELAY: begin
                    nxt_rdata = delay_ff;
                end
                `UCB_ADDR_STATE: begin
                    nxt_rdata[`UCB_ST_START] = unbalance_general_start_o;
                    nxt_rdata[`UCB_ST_TRIP] = unbalance_general_trip_o;
                    nxt_rdata[`UCB_ST_DIFF] = diff_flag;
                    nxt_rdata[`UCB_ST_SUFFICIENT] = max_current_sufficient_flag;
                    nxt_rdata[`UCB_ST_BELOW_FAULT] = max_current_below_fault_flag;
                end
                `UCB_ADDR_INT_STAT: begin
                    nxt_rdata = {12'h000, int_stat_ff};
                end
                `UCB_ADDR_INT_MASK: begin
                    nxt_rdata = {12'h000, int_mask_ff};
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            enable_ff <= `UCB_RST_ENABLE; // [R1]
            start_only_ff <= `UCB_RST_START_ONLY; // [R5]
            pct_ff <= `UCB_RST_PCT; // [R6]
            delay_ff <= `UCB_RST_DELAY; // [R7]
            int_stat_ff <= 4'h0;
            int_mask_ff <= `UCB_RST_MASK;
            pre_ff <= {PRE_W{1'b0}};
            ms_ff <= 16'h0000;
            reg_rdata_o <= 16'h0000;
            unbalance_general_start_o <= 1'b0;
            unbalance_general_trip_o <= 1'b0;
            start_event_o <= 1'b0;
            start_event_value_o <= 1'b0;
            trip_event_o <= 1'b0;
            trip_event_value_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            enable_ff <= nxt_enable;
            start_only_ff <= nxt_start_only;
            pct_ff <= nxt_pct;
            delay_ff <= nxt_delay;
            int_stat_ff <= nxt_int_stat;
            int_mask_ff <= nxt_int_mask;
            pre_ff <= nxt_pre;
            ms_ff <= nxt_ms;
            reg_rdata_o <= nxt_rdata;
            unbalance_general_start_o <= nxt_start; // [R10]
            unbalance_general_trip_o <= nxt_trip; // [R11]
            start_event_o <= nxt_start != unbalance_general_start_o; // [R12]
            start_event_value_o <= nxt_start; // [R12]
            trip_event_o <= nxt_trip != unbalance_general_trip_o; // [R12]
            trip_event_value_o <= nxt_trip; // [R12]
            irq_o <= |(nxt_int_stat & nxt_int_mask);
        end
    end

endmodule
`default_nettype wire

// ### hw/ucb_evaluate.v
// Phase magnitude evaluation: unbalance percentage and current window flags.
// Assumes magnitudes come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "ucb_defs.vh"

module ucb_evaluate #(
    parameter MAG_W = 16,
    parameter [MAG_W-1:0] RATED_MAG = 16'h1000
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_b_i,
    // Magnitudes and setting
    input wire [MAG_W-1:0] mag_l1_i,
    input wire [MAG_W-1:0] mag_l2_i,
    input wire [MAG_W-1:0] mag_l3_i,
    input wire [6:0] pct_i,
    // Flags
    output reg diff_flag_o,
    output reg max_current_sufficient_flag_o,
    output reg max_current_below_fault_flag_o
);

    localparam W = MAG_W + 16;

    reg [MAG_W-1:0] max_mag;
    reg [MAG_W-1:0] min_mag;
    reg [W-1:0] diff_scaled;
    reg [W-1:0] limit;
    reg [W-1:0] diff_hyst;
    reg [W-1:0] limit_hyst;
    reg nxt_diff;

    // ==========================================================
    // Largest and smallest phase
    always @* begin
        max_mag = mag_l1_i;
        min_mag = mag_l1_i;
        if (mag_l2_i > max_mag) begin
            max_mag = mag_l2_i;
        end
        if (mag_l3_i > max_mag) begin
            max_mag = mag_l3_i;
        end
        if (mag_l2_i < min_mag) begin
            min_mag = mag_l2_i;
        end
        if (mag_l3_i < min_mag) begin
            min_mag = mag_l3_i;
        end
    end

    // ==========================================================
    // Percentage compare with reset ratio
    always @* begin
        diff_scaled = {{(W-MAG_W){1'b0}}, max_mag - min_mag} * {{(W-7){1'b0}}, `UCB_PERCENT};
        limit = {{(W-MAG_W){1'b0}}, max_mag} * {{(W-7){1'b0}}, pct_i};
        diff_hyst = diff_scaled * {{(W-5){1'b0}}, `UCB_RESET_DEN};
        limit_hyst = limit * {{(W-5){1'b0}}, `UCB_RESET_NUM};
        nxt_diff = diff_flag_o;
        if (diff_scaled > limit) begin
            nxt_diff = 1'b1; // [R2]
        end else if (diff_hyst < limit_hyst) begin
            nxt_diff = 1'b0; // [R13]
        end
    end

    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            diff_flag_o <= 1'b0;
            max_current_sufficient_flag_o <= 1'b0;
            max_current_below_fault_flag_o <= 1'b0;
        end else begin
            diff_flag_o <= nxt_diff;
            // Above one tenth of rated current
            max_current_sufficient_flag_o <= ({{(W-MAG_W){1'b0}}, max_mag}
                * {{(W-4){1'b0}}, `UCB_LOW_DIV}) > {{(W-MAG_W){1'b0}}, RATED_MAG}; // [R3]
            // Below one and a half times rated current
            max_current_below_fault_flag_o <= ({{(W-MAG_W){1'b0}}, max_mag}
                * {{(W-2){1'b0}}, `UCB_HIGH_DEN})
                < ({{(W-MAG_W){1'b0}}, RATED_MAG} * {{(W-2){1'b0}}, `UCB_HIGH_NUM}); // [R4]
        end
    end

endmodule
`default_nettype wire

// ### include/ucb_defs.vh
// Constants of the current unbalance decision block.
// Assumes inclusion by bare name from the design files.
`ifndef UCB_DEFS_VH
`define UCB_DEFS_VH

// ==========================================================
// Register indices
`define UCB_ADDR_CTRL 4'h0
`define UCB_ADDR_PCT 4'h1
`define UCB_ADDR_DELAY 4'h2
`define UCB_ADDR_STATE 4'h3
`define UCB_ADDR_INT_STAT 4'h4
`define UCB_ADDR_INT_MASK 4'h5

// ==========================================================
// Field positions
`define UCB_CTRL_ENABLE 0
`define UCB_CTRL_START_ONLY 1
`define UCB_ST_START 0
`define UCB_ST_TRIP 1
`define UCB_ST_DIFF 2
`define UCB_ST_SUFFICIENT 3
`define UCB_ST_BELOW_FAULT 4
`define UCB_INT_START_ON 0
`define UCB_INT_START_OFF 1
`define UCB_INT_TRIP_ON 2
`define UCB_INT_TRIP_OFF 3

// ==========================================================
// Reset values and setting ranges
`define UCB_RST_ENABLE 1'h0
`define UCB_RST_START_ONLY 1'h0
`define UCB_RST_PCT 7'h32
`define UCB_PCT_MIN 7'h0A
`define UCB_PCT_MAX 7'h5A
`define UCB_RST_DELAY 16'h03E8
`define UCB_DELAY_MIN 16'h0064
`define UCB_DELAY_MAX 16'hEA60
`define UCB_RST_MASK 4'h0

// ==========================================================
// Ratios: window 1/10 and 3/2 of rated, reset ratio 19/20
`define UCB_LOW_DIV 4'hA
`define UCB_HIGH_NUM 2'h3
`define UCB_HIGH_DEN 2'h2
`define UCB_RESET_NUM 5'h13
`define UCB_RESET_DEN 5'h14
`define UCB_PERCENT 7'h64

// ==========================================================
// Timing
`define UCB_CLK_HZ 50000000
`define UCB_TICK_US 1000
`define UCB_TICK_CYCLES ((`UCB_CLK_HZ / 1000000) * `UCB_TICK_US)

`endif

// ### tb/test_ucb_decision.sv
// Bench for the unbalance decision block: registers, magnitudes, blocking.
// Assumes the Fourier stand-in drives the magnitudes; ms tick is 4 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "ucb_defs.vh"
module test_ucb_decision;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [15:0] s1 = 16'h0, s2 = 16'h0, s3 = 16'h0, m1, m2, m3, wdata = 16'h0, rdata;
    logic [3:0] addr = 4'h0;
    logic wr_s = 1'b0, rd_s = 1'b0, blk = 1'b0;
    logic start, trip, sev, sval, tev, tval, irq;
    int error_cnt = 0;
    int checks_done = 0;
    always #10 clock_i = ~clock_i;
    ucb_fourier_model #(.MAG_W(16)) u_src (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .set_l1_i(s1), .set_l2_i(s2), .set_l3_i(s3),
        .mag_l1_o(m1), .mag_l2_o(m2), .mag_l3_o(m3));
    ucb_decision #(.TICK_CYCLES(4)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .mag_l1_i(m1), .mag_l2_i(m2), .mag_l3_i(m3), .unbalance_block_input_i(blk),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .unbalance_general_start_o(start),
        .unbalance_general_trip_o(trip), .start_event_o(sev), .start_event_value_o(sval),
        .trip_event_o(tev), .trip_event_value_o(tval), .irq_o(irq));
    // ==========================================================
    // Tasks
    task automatic stop_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock_i);
        wr_s <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock_i);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic mags(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clock_i);
        s1 <= a;
        s2 <= b;
        s3 <= c;
        #1;
    endtask
    task automatic wait_for(input logic sel, input logic lvl, input int lim, output int n);
        n = 0;
        while (((sel ? trip : start) !== lvl) && n < lim) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, sel ? trip : start, lvl);
            stop_test();
        end
    endtask
    task automatic step(input logic [15:0] a, b, c, input logic e);
        mags(a, b, c);
        idle(6);
        chk(16'(start), 16'(e));
    endtask
    // ==========================================================
    // Sequence
    initial begin
        int n;
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        #1;
        rd_chk(`UCB_ADDR_CTRL, 16'h0000);
        rd_chk(`UCB_ADDR_PCT, 16'h0032);
        rd_chk(`UCB_ADDR_DELAY, 16'h03E8);
        rd_chk(`UCB_ADDR_INT_MASK, 16'h0000);
        rd_chk(4'hF, 16'h0000);
        wr(`UCB_ADDR_PCT, 16'h0005);
        rd_chk(`UCB_ADDR_PCT, 16'h000A);
        wr(`UCB_ADDR_PCT, 16'h0064);
        rd_chk(`UCB_ADDR_PCT, 16'h005A);
        wr(`UCB_ADDR_PCT, 16'h0032);
        wr(`UCB_ADDR_DELAY, 16'hFFFF);
        rd_chk(`UCB_ADDR_DELAY, 16'hEA60);
        wr(`UCB_ADDR_DELAY, 16'h0005);
        rd_chk(`UCB_ADDR_DELAY, 16'h0064);
        mags(16'h0FA0, 16'h0FA0, 16'h03E8);
        idle(10);
        chk(16'(start), 16'h0000);
        wr(`UCB_ADDR_CTRL, 16'h0001);
        wait_for(1'b0, 1'b1, 20, n);
        chk(16'({sev, sval, irq}), 16'h0006);
        wait_for(1'b1, 1'b1, 500, n);
        chk(16'(n), 16'h018F);
        chk(16'({tev, tval}), 16'h0003);
        wr(`UCB_ADDR_INT_MASK, 16'h000F);
        idle(1);
        chk(16'(irq), 16'h0001);
        rd_chk(`UCB_ADDR_STATE, 16'h001F);
        rd_chk(`UCB_ADDR_INT_STAT, 16'h0005);
        idle(1);
        chk(16'(irq), 16'h0000);
        mags(16'h07D0, 16'h07D0, 16'h07D0);
        wait_for(1'b0, 1'b0, 10, n);
        chk(16'({trip, sev, sval, tev, tval}), 16'h000A);
        rd_chk(`UCB_ADDR_INT_STAT, 16'h000A);
        mags(16'h0FA0, 16'h0FA0, 16'h03E8);
        wait_for(1'b0, 1'b1, 20, n);
        idle(200);
        mags(16'h07D0, 16'h07D0, 16'h07D0);
        wait_for(1'b0, 1'b0, 10, n);
        mags(16'h0FA0, 16'h0FA0, 16'h03E8);
        wait_for(1'b0, 1'b1, 20, n);
        wait_for(1'b1, 1'b1, 500, n);
        chk(16'(n), 16'h018F);
        @(posedge clock_i);
        blk <= 1'b1;
        idle(2);
        chk(16'({start, trip}), 16'h0000);
        @(posedge clock_i);
        blk <= 1'b0;
        wait_for(1'b0, 1'b1, 20, n);
        wr(`UCB_ADDR_CTRL, 16'h0003);
        idle(600);
        chk(16'({start, trip}), 16'h0002);
        wr(`UCB_ADDR_CTRL, 16'h0001);
        step(16'h0FA0, 16'h0FA0, 16'h0FA0, 1'b0);
        step(16'h0FA0, 16'h07D0, 16'h0BB8, 1'b0);
        step(16'h0FA0, 16'h07CF, 16'h0BB8, 1'b1);
        step(16'h0FA0, 16'h0834, 16'h0BB8, 1'b1);
        step(16'h0FA0, 16'h083E, 16'h0BB8, 1'b0);
        step(16'h0199, 16'h0000, 16'h0000, 1'b0);
        step(16'h019A, 16'h0000, 16'h0000, 1'b1);
        step(16'h1800, 16'h0000, 16'h0000, 1'b0);
        step(16'h17FF, 16'h0000, 16'h0000, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire

// ### tb/ucb_decision_checker.sv
// Checker of the start, trip and event outputs.
// Assumes binding to ucb_decision; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module ucb_decision_checker #(
    parameter MAG_W = 16,
    parameter [MAG_W-1:0] RATED_MAG = 16'h1000,
    parameter TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Inputs watched
    input wire logic [MAG_W-1:0] mag_l1_i,
    input wire logic [MAG_W-1:0] mag_l2_i,
    input wire logic [MAG_W-1:0] mag_l3_i,
    input wire logic unbalance_block_input_i,
    // Outputs watched
    input wire logic unbalance_general_start_o,
    input wire logic unbalance_general_trip_o,
    input wire logic start_event_o,
    input wire logic start_event_value_o,
    input wire logic trip_event_o,
    input wire logic trip_event_value_o
);
    localparam int MIN_TRIP = 100 * TICK_CYCLES - 1;
    logic [31:0] hi1_ff, hi2_ff, lo1_ff, lo2_ff, run_ff;
    function automatic logic [31:0] hi3(input logic [MAG_W-1:0] a, b, c);
        hi3 = 32'((a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c));
    endfunction
    function automatic logic [31:0] lo3(input logic [MAG_W-1:0] a, b, c);
        lo3 = 32'((a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c));
    endfunction
    // ==========================================================
    // Max and min two cycles back, length of the start run
    always @(posedge clock_i) begin
        hi1_ff <= hi3(mag_l1_i, mag_l2_i, mag_l3_i);
        lo1_ff <= lo3(mag_l1_i, mag_l2_i, mag_l3_i);
        hi2_ff <= hi1_ff;
        lo2_ff <= lo1_ff;
        run_ff <= (!rst_b_i || !unbalance_general_start_o) ? 32'h0 : run_ff + 32'h1;
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    a_block_clears: assert property (
        unbalance_block_input_i |=> !unbalance_general_start_o && !unbalance_general_trip_o)
        else $error("output active after block");
    a_start_unblocked: assert property (
        $rose(unbalance_general_start_o) |-> !$past(unbalance_block_input_i))
        else $error("start rose while blocked");
    a_start_window: assert property (
        $rose(unbalance_general_start_o) |->
        hi2_ff * 10 > 32'(RATED_MAG) && hi2_ff * 2 < 32'(RATED_MAG) * 3)
        else $error("start outside current window");
    a_start_diff: assert property (
        $rose(unbalance_general_start_o) |-> (hi2_ff - lo2_ff) * 200 >= hi2_ff * 19)
        else $error("start without unbalance");
    a_start_event: assert property (
        start_event_o == $changed(unbalance_general_start_o) &&
        (!start_event_o || start_event_value_o == unbalance_general_start_o))
        else $error("start event mismatch");
    a_trip_event_on: assert property (
        $changed(unbalance_general_trip_o) |->
        trip_event_o && trip_event_value_o == unbalance_general_trip_o)
        else $error("trip change without event");
    a_trip_event_cause: assert property (
        trip_event_o |-> $changed(unbalance_general_trip_o))
        else $error("trip event without change");
    a_trip_needs_start: assert property (
        unbalance_general_trip_o |-> unbalance_general_start_o)
        else $error("trip without start");
    a_trip_min_delay: assert property (
        $rose(unbalance_general_trip_o) |-> run_ff >= MIN_TRIP)
        else $error("trip before minimum delay");
    c_start: cover property ($rose(unbalance_general_start_o));
    c_trip: cover property ($rose(unbalance_general_trip_o));
    c_block: cover property (unbalance_general_start_o && unbalance_block_input_i);
endmodule
bind ucb_decision ucb_decision_checker #(
    .MAG_W(MAG_W),
    .RATED_MAG(RATED_MAG),
    .TICK_CYCLES(TICK_CYCLES)
) u_chk (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .mag_l1_i(mag_l1_i),
    .mag_l2_i(mag_l2_i),
    .mag_l3_i(mag_l3_i),
    .unbalance_block_input_i(unbalance_block_input_i),
    .unbalance_general_start_o(unbalance_general_start_o),
    .unbalance_general_trip_o(unbalance_general_trip_o),
    .start_event_o(start_event_o),
    .start_event_value_o(start_event_value_o),
    .trip_event_o(trip_event_o),
    .trip_event_value_o(trip_event_value_o)
);
`default_nettype wire

// ### tb/ucb_fourier_model.sv
// Fourier stage stand-in: holds the phase magnitudes set by the bench.
// Assumes targets change just after a rising edge of the shared clock.
`timescale 1ns/100ps
`default_nettype none
module ucb_fourier_model #(
    parameter MAG_W = 16
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Targets from the bench
    input wire logic [MAG_W-1:0] set_l1_i,
    input wire logic [MAG_W-1:0] set_l2_i,
    input wire logic [MAG_W-1:0] set_l3_i,
    // Magnitudes to the block
    output logic [MAG_W-1:0] mag_l1_o,
    output logic [MAG_W-1:0] mag_l2_o,
    output logic [MAG_W-1:0] mag_l3_o
);
    logic [3*MAG_W-1:0] mag_ff;
    assign {mag_l1_o, mag_l2_o, mag_l3_o} = mag_ff;
    always @(posedge clock_i) begin
        mag_ff <= !rst_b_i ? '0 : {set_l1_i, set_l2_i, set_l3_i};
    end
endmodule
`default_nettype wire
